// *** bench/link_host_model.sv ***
// behavioural host controller driving lock/unlock data blocks onto the link
`timescale 1ns/1ps
module link_host_model (
	output logic link_clk,
	output logic link_frame,
	output logic [7:0] link_data
);
	// link clock parked low between frames, data left scrambled
	initial begin
		link_clk = 1'b0;
		link_frame = 1'b0;
		link_data = 8'hA5;
	end

	////////////////////////////////////////////////////////////////////////
	// one block: mode byte, length byte, password bytes
	// data moves while the link clock is low so each rise sees it settled
	task automatic send_block(input logic [7:0] blk [0:5], input int n);
		#1.3;
		link_frame = 1'b1;
		for (int i = 0; i < n; i++) begin
			link_data = blk[i];
			#62.5 link_clk = 1'b1;
			#62.5 link_clk = 1'b0;
		end
		link_data = ~link_data; // released line must not keep last byte
		#62.5 link_frame = 1'b0;
	endtask
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the card lock and status block
`timescale 1ns/1ps
`include "card_lock_regs.svh"
module testbench;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, ev_flags, card_status, resp_status;
	logic [31:0] v;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] link_data, block_len;
	logic [3:0] card_state;
	logic link_clk, link_frame, cmd_valid, cmd_crc_fail, cmd_illegal;
	logic buffer_empty, ecc_disabled, locked_access, card_locked;
	logic content_wipe, engine_busy;
	logic [7:0] blk [0:5];
	int fail_count = 0;
	int total_checks = 0;
	int wipe_count = 0;
	localparam logic [31:0] base_st = 32'h0000_0900;
	localparam logic [31:0] lk = 32'h0200_0000;
	localparam logic [31:0] fl = 32'h0100_0000;

	// single slave, so its ready is the bus ready
	assign hready = hreadyout;

	// bus clock
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	// count wipe pulses so a refused erase cannot hide one
	always @(posedge hclk) begin
		if (content_wipe === 1'b1) wipe_count++;
	end

	card_lock_unlock_and_status u_card_lock_unlock_and_status (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .link_clk(link_clk), .link_frame(link_frame),
		.link_data(link_data), .cmd_valid(cmd_valid),
		.cmd_crc_fail(cmd_crc_fail), .cmd_illegal(cmd_illegal),
		.card_state(card_state), .block_len(block_len),
		.buffer_empty(buffer_empty), .ecc_disabled(ecc_disabled),
		.ev_flags(ev_flags), .locked_access(locked_access),
		.card_status(card_status), .resp_status(resp_status),
		.card_locked(card_locked), .content_wipe(content_wipe),
		.engine_busy(engine_busy)
	);

	link_host_model u_link_host_model (
		.link_clk(link_clk), .link_frame(link_frame), .link_data(link_data)
	);

	////////////////////////////////////////////////////////////////////////
	// reporting
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// bus master: bounded waits, a spent bound ends the run
	task automatic wait_ready();
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (k >= 50) begin
			fail_count++;
			tally_and_finish();
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		haddr <= {24'h0, a};
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		v = hrdata;
	endtask

	// one frame, then the mandatory gap and the engine's own completion
	task automatic send(input int n);
		u_link_host_model.send_block(blk, n);
		repeat (20) @(posedge hclk);
		for (int k = 0; k < 40 && engine_busy !== 1'b0; k++) @(posedge hclk);
		if (engine_busy !== 1'b0) begin
			fail_count++;
			tally_and_finish();
		end
		repeat (4) @(posedge hclk);
	endtask

	// one-cycle command side pulses
	task automatic pulse(input logic [2:0] c, input logic [31:0] ev,
		input logic la);
		cmd_crc_fail <= c[2];
		cmd_illegal <= c[1];
		cmd_valid <= c[0];
		ev_flags <= ev;
		locked_access <= la;
		@(posedge hclk);
		{cmd_crc_fail, cmd_illegal, cmd_valid, locked_access} <= 4'h0;
		ev_flags <= 32'h0;
		repeat (3) @(posedge hclk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		hresetn = 1'b0;
		{hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
		{cmd_valid, cmd_crc_fail, cmd_illegal, locked_access} = 4'h0;
		ev_flags = 32'h0;
		card_state = 4'h4;
		block_len = 8'h06;
		buffer_empty = 1'b1;
		ecc_disabled = 1'b0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
		check("status", card_status, base_st);
		bus(1'b1, `REG_STORED_PASSWORD_LENGTH, 32'h4);
		bus(1'b1, `REG_PWD_BASE, 32'h4433_2211);
		bus(1'b1, `REG_CTRL, 32'h1);
		repeat (4) @(posedge hclk);
		check("locked", {31'h0, card_locked}, 32'h1);
		check("status", card_status, lk | base_st);
		blk = '{8'h00, 8'h04, 8'h11, 8'h22, 8'h33, 8'h55};
		send(6);
		check("status", card_status, lk | fl | base_st);
		bus(1'b0, `REG_STATUS, 32'h0);
		check("rd status", v, lk | fl | base_st);
		repeat (2) @(posedge hclk);
		check("status", card_status, lk | base_st);
		blk[5] = 8'h44;
		send(6);
		check("locked", {31'h0, card_locked}, 32'h0);
		check("status", card_status, base_st);
		send(6);
		bus(1'b0, `REG_STATUS, 32'h0);
		check("rd status", v, fl | base_st);
		block_len <= 8'h01;
		blk[0] = 8'h08;
		send(1);
		bus(1'b0, `REG_STATUS, 32'h0);
		check("rd status", v, fl | base_st);
		check("wipes", wipe_count, 32'h0);
		bus(1'b1, `REG_CTRL, 32'h1);
		repeat (4) @(posedge hclk);
		check("locked", {31'h0, card_locked}, 32'h1);
		blk[0] = 8'h0C;
		send(1);
		bus(1'b0, `REG_STATUS, 32'h0);
		check("rd status", v, lk | fl | base_st);
		check("wipes", wipe_count, 32'h0);
		blk[0] = 8'h08;
		send(1);
		check("wipes", wipe_count, 32'h1);
		check("locked", {31'h0, card_locked}, 32'h0);
		bus(1'b0, `REG_STORED_PASSWORD_LENGTH, 32'h0);
		check("stored_password_length", v, 32'h0);
		bus(1'b1, `REG_CTRL, 32'h1);
		repeat (4) @(posedge hclk);
		check("locked", {31'h0, card_locked}, 32'h0);
		block_len <= 8'h03;
		send(2);
		bus(1'b0, `REG_STATUS, 32'h0);
		check("rd status", v, 32'h2000_0900);
		pulse(3'b110, 32'h0, 1'b0);
		check("status", card_status, 32'h00C0_0900);
		pulse(3'b001, 32'h0, 1'b0);
		check("resp", resp_status, 32'h00C0_0900);
		check("status", card_status, base_st);
		pulse(3'b000, 32'h0, 1'b1);
		check("status", card_status, fl | base_st);
		pulse(3'b000, 32'hFD3F_A03F, 1'b0);
		check("status", card_status, 32'hFD3F_A920);
		pulse(3'b001, 32'h0, 1'b0);
		check("resp", resp_status, 32'hFD3F_A920);
		check("status", card_status, base_st);
		buffer_empty <= 1'b0;
		ecc_disabled <= 1'b1;
		for (int s = 0; s < 9; s++) begin
			card_state <= s[3:0];
			repeat (3) @(posedge hclk);
			check("state", card_status, {19'h2, s[3:0], 9'h0});
		end
		tally_and_finish();
	end
endmodule

// *** rtl/card_lock_pkg.sv ***
// types shared by the card lock block
package card_lock_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RECV = 3'h1,
		ST_DECIDE = 3'h2,
		ST_READ = 3'h3,
		ST_CMP = 3'h4,
		ST_FINISH = 3'h5,
		ST_ERASE = 3'h6
	} engine_state_type;

	typedef enum logic [3:0] {
		CS_IDLE = 4'h0,
		CS_READY = 4'h1,
		CS_IDENT = 4'h2,
		CS_STBY = 4'h3,
		CS_TRAN = 4'h4,
		CS_DATA = 4'h5,
		CS_RCV = 4'h6,
		CS_PRG = 4'h7,
		CS_DIS = 4'h8
	} card_state_type;

endpackage

// *** rtl/card_lock_regs.svh ***
// register offsets, status bit layout and engine constants of the card lock block
//
// Contract
// - matching password on unlock request unlocks card, clears locked bit
// - mismatching password on unlock request sets lock-request-failed bit
// - unlock lasts one session; stored password relocks card at power-up
// - unlock request to an unlocked card fails with lock-request-failed
// - forced-erase byte with any other bit set is rejected and flagged
// - accepted forced erase wipes content, password and length, then unlocks
// - forced erase on unlocked card fails, keeps content, flags failure
// - each response carries a 32-bit status about the previous command
// - execution-time bits are latched and shown by a later status read
// - bits clear by class: state-following, next valid command, or on read
// - bits 31 to 26 flag argument, address, length, erase, protect faults
// - bit 25 follows the current lock state, never cleared by read
// - bit 24 flags lock sequence or password error, or locked access
// - bit 23 command check fault, bit 22 disallowed command; next command
// - bits 21, 20, 19, 16 flag correction, controller, general, overwrite
// - bit 18 stream read underrun, bit 17 stream write overrun; read-clear
// - bit 15 partial erase, bit 13 erase abort read-clear, bit 14 no ECC
// - bits 12:9 carry card state at command receipt as binary code
// - bit 8 is one while the data buffer is empty and ready
// - bit 5 application command expected, read-clear; 7:6 and 4:0 reserved
// - block holds mode byte, length byte, then password bytes
`ifndef CARD_LOCK_REGS_SVH
`define CARD_LOCK_REGS_SVH

// bus register byte offsets
`define REG_STATUS 8'h00
`define REG_RESP 8'h04
`define REG_CTRL 8'h08
`define REG_STORED_PASSWORD_LENGTH 8'h0C
`define REG_PWD_BASE 8'h10
`define REG_PWD_LAST 8'h1C

// control register bits
`define CTRL_SESSION_BIT 0
`define CTRL_BUSY_BIT 1

// status bit positions
`define ST_BLOCK_LEN_BIT 29
`define ST_LOCKED_BIT 25
`define ST_LOCK_FAIL_BIT 24
`define ST_CMD_CRC_BIT 23
`define ST_ILLEGAL_BIT 22
`define ST_ECC_OFF_BIT 14
`define ST_STATE_LSB 9
`define ST_READY_BIT 8
// clear-on-read bits: 31..26, 24, 21..16, 15, 13, 5
`define ST_READ_CLEAR_MASK 32'hFD3FA020

// mode byte bits of the lock/unlock data block
`define MODE_ERASE_BIT 3
`define MODE_LOCK_BIT 2
`define MODE_CLR_BIT 1
`define MODE_SET_BIT 0
`define MODE_ERASE_ONLY 8'h08

// password store geometry
`define PWD_MAX_BYTES 8'h10
`define PWD_WORDS 4
`define HDR_BYTES 8'h02

`endif

// *** rtl/card_lock_unlock_and_status.sv ***
// card lock/unlock engine, card status field and its bus registers
`timescale 1ns/1ps
`include "card_lock_regs.svh"
module card_lock_unlock_and_status (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic link_clk,
	input wire logic link_frame,
	input wire logic [7:0] link_data,
	input wire logic cmd_valid,
	input wire logic cmd_crc_fail,
	input wire logic cmd_illegal,
	input wire logic [3:0] card_state,
	input wire logic [7:0] block_len,
	input wire logic buffer_empty,
	input wire logic ecc_disabled,
	input wire logic [31:0] ev_flags,
	input wire logic locked_access,
	output logic [31:0] card_status,
	output logic [31:0] resp_status,
	output logic card_locked,
	output logic content_wipe,
	output logic engine_busy
);

	card_lock_pkg::engine_state_type state_q, state_d;
	logic card_locked_flag;
	logic [7:0] stored_password_length;
	logic [31:0] read_clear_q;
	logic command_check_fault, disallowed_command_fault;
	logic [31:0] status_d;
	logic fail_set, len_fault_set, unlock_ok, erase_done, session_q;
	logic [7:0] mode_q, rxlen_q, cnt_q;
	logic [127:0] rx_pwd_q;
	logic [1:0] idx_q;
	logic mism_q;
	logic [31:0] mem_rdata, mem_wdata;
	logic mem_we;
	logic [1:0] mem_waddr;
	logic clk_s1, clk_s2, clk_s3, fr_s1, fr_s2, fr_s3;
	logic [7:0] dat_s1, dat_s2;
	logic link_rise, frame_fall;
	logic ap_valid, dp_write_q, status_rd;
	logic [7:0] dp_addr_q;
	logic session_wr, pwd_wr;

	////////////////////////////////////////////////////////////////////////
	// bus slave

	assign ap_valid = hsel && htrans[1] && hready;
	// software view of the status counts as a read, so it clears C bits
	assign status_rd = ap_valid && !hwrite && haddr[7:0] == `REG_STATUS;
	assign session_wr = dp_write_q && dp_addr_q == `REG_CTRL &&
		hwdata[`CTRL_SESSION_BIT];
	// password writes are dropped while the engine owns the store
	assign pwd_wr = dp_write_q && state_q == card_lock_pkg::ST_IDLE &&
		dp_addr_q >= `REG_PWD_BASE && dp_addr_q <= `REG_PWD_LAST;

	// address phase captured for the write data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write_q <= 1'b0;
			dp_addr_q <= 8'h00;
		end else begin
			dp_write_q <= ap_valid && hwrite;
			dp_addr_q <= haddr[7:0];
		end
	end

	// read data chosen at the address phase, zero wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (ap_valid && !hwrite) begin
			case (haddr[7:0])
				`REG_STATUS: hrdata <= card_status;
				`REG_RESP: hrdata <= resp_status;
				`REG_CTRL: hrdata <= {30'h0000_0000, engine_busy, card_locked};
				`REG_STORED_PASSWORD_LENGTH: hrdata <= {24'h00_0000, stored_password_length};
				default: hrdata <= 32'h0000_0000; // password words read zero
			endcase
		end
	end

	// always ready, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link inputs: two flops each, then edge detection on later stages

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_s1 <= 1'b0;
			clk_s2 <= 1'b0;
			clk_s3 <= 1'b0;
			fr_s1 <= 1'b0;
			fr_s2 <= 1'b0;
			fr_s3 <= 1'b0;
			dat_s1 <= 8'h00;
			dat_s2 <= 8'h00;
		end else begin
			clk_s1 <= link_clk;
			clk_s2 <= clk_s1;
			clk_s3 <= clk_s2;
			fr_s1 <= link_frame;
			fr_s2 <= fr_s1;
			fr_s3 <= fr_s2;
			dat_s1 <= link_data;
			dat_s2 <= dat_s1;
		end
	end

	// data and clock share the same delay, so bytes stay aligned
	assign link_rise = clk_s2 && !clk_s3;
	assign frame_fall = fr_s3 && !fr_s2;

	////////////////////////////////////////////////////////////////////////
	// block receiver: mode byte, length byte, password bytes

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 8'h00;
			mode_q <= 8'h00;
			rxlen_q <= 8'h00;
			rx_pwd_q <= '0;
		end else if (state_q == card_lock_pkg::ST_IDLE && !fr_s2) begin
			cnt_q <= 8'h00;
		end else if ((state_q == card_lock_pkg::ST_IDLE ||
			state_q == card_lock_pkg::ST_RECV) && link_rise && fr_s2) begin
			if (cnt_q == 8'h00) begin
				mode_q <= dat_s2;
			end else if (cnt_q == 8'h01) begin
				rxlen_q <= dat_s2;
			end else if (cnt_q < `PWD_MAX_BYTES + `HDR_BYTES) begin
				rx_pwd_q[(cnt_q - `HDR_BYTES) * 8 +: 8] <= dat_s2;
			end
			if (cnt_q != 8'hFF) begin
				cnt_q <= cnt_q + 8'h01; // saturates on oversize blocks
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// lock engine

	// byte lanes of password word idx that lie inside the length
	function automatic logic [31:0] lane_mask(input logic [1:0] idx,
		input logic [7:0] len);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int b = 0; b < 4; b++) begin
			if ({4'h0, idx, 2'(b)} < len) begin
				m[b*8 +: 8] = 8'hFF;
			end
		end
		return m;
	endfunction

	always_comb begin
		state_d = state_q;
		fail_set = 1'b0;
		len_fault_set = 1'b0;
		unlock_ok = 1'b0;
		erase_done = 1'b0;
		case (state_q)
			card_lock_pkg::ST_IDLE: begin
				if (link_rise && fr_s2) begin
					state_d = card_lock_pkg::ST_RECV;
				end
			end
			card_lock_pkg::ST_RECV: begin
				if (frame_fall) begin
					state_d = card_lock_pkg::ST_DECIDE;
				end
			end
			card_lock_pkg::ST_DECIDE: begin
				state_d = card_lock_pkg::ST_IDLE;
				if (cnt_q != block_len) begin
					len_fault_set = 1'b1; // block not as announced
				end else if (mode_q[`MODE_ERASE_BIT]) begin
					if (mode_q != `MODE_ERASE_ONLY) begin
						fail_set = 1'b1;
					end else if (!card_locked_flag) begin
						fail_set = 1'b1;
					end else begin
						state_d = card_lock_pkg::ST_ERASE;
					end
				end else if (mode_q[2:0] == 3'h0) begin
					if (!card_locked_flag) begin
						fail_set = 1'b1;
					end else if (rxlen_q != stored_password_length ||
						rxlen_q > `PWD_MAX_BYTES) begin
						fail_set = 1'b1; // size differs
					end else begin
						state_d = card_lock_pkg::ST_READ;
					end
				end
			end
			card_lock_pkg::ST_READ: begin
				state_d = card_lock_pkg::ST_CMP;
			end
			card_lock_pkg::ST_CMP: begin
				state_d = (idx_q == 2'h3) ? card_lock_pkg::ST_FINISH :
					card_lock_pkg::ST_READ;
			end
			card_lock_pkg::ST_FINISH: begin
				state_d = card_lock_pkg::ST_IDLE;
				fail_set = mism_q;
				unlock_ok = !mism_q;
			end
			card_lock_pkg::ST_ERASE: begin
				if (idx_q == 2'h3) begin
					erase_done = 1'b1;
					state_d = card_lock_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = card_lock_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= card_lock_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// word walk through the store, mismatch accumulated over masked lanes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idx_q <= 2'h0;
			mism_q <= 1'b0;
		end else if (state_q == card_lock_pkg::ST_DECIDE) begin
			idx_q <= 2'h0;
			mism_q <= 1'b0;
		end else if (state_q == card_lock_pkg::ST_CMP) begin
			if (((mem_rdata ^ rx_pwd_q[idx_q*32 +: 32]) &
				lane_mask(idx_q, rxlen_q)) != 32'h0000_0000) begin
				mism_q <= 1'b1;
			end
			idx_q <= idx_q + 2'h1;
		end else if (state_q == card_lock_pkg::ST_ERASE) begin
			idx_q <= idx_q + 2'h1;
		end
	end

	// the engine wins the write port; bus writes only land when idle
	assign mem_we = state_q == card_lock_pkg::ST_ERASE || pwd_wr;
	assign mem_waddr = (state_q == card_lock_pkg::ST_ERASE) ? idx_q :
		dp_addr_q[3:2];
	assign mem_wdata = (state_q == card_lock_pkg::ST_ERASE) ?
		32'h0000_0000 : hwdata;

	pwd_store #(
		.WIDTH(32),
		.DEPTH(`PWD_WORDS),
		.AW(2)
	) u_store (
		.clk(hclk),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(idx_q),
		.rdata(mem_rdata)
	);

	// session start: first cycle after reset, or software power-up pulse
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			session_q <= 1'b1;
		end else begin
			session_q <= session_wr;
		end
	end

	// stored length; forced erase zeroes it, bus may load it when idle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stored_password_length <= 8'h00;
		end else if (erase_done) begin
			stored_password_length <= 8'h00;
		end else if (dp_write_q && dp_addr_q == `REG_STORED_PASSWORD_LENGTH &&
			state_q == card_lock_pkg::ST_IDLE) begin
			stored_password_length <= hwdata[7:0];
		end
	end

	// lock state: a set password relocks at each session start
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			card_locked_flag <= 1'b0;
		end else if (session_q) begin
			card_locked_flag <= stored_password_length != 8'h00;
		end else if (unlock_ok || erase_done) begin
			card_locked_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status bits

	// read-clear class: a set in the clearing cycle survives
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			read_clear_q <= 32'h0000_0000;
		end else begin
			read_clear_q <= ((cmd_valid || status_rd) ? 32'h0000_0000 :
				read_clear_q) | (ev_flags & `ST_READ_CLEAR_MASK) |
				({31'h0000_0000, fail_set || locked_access} <<
				`ST_LOCK_FAIL_BIT) | ({31'h0000_0000, len_fault_set} <<
				`ST_BLOCK_LEN_BIT);
		end
	end

	// previous-command class: cleared by the next valid command
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			command_check_fault <= 1'b0;
			disallowed_command_fault <= 1'b0;
		end else begin
			command_check_fault <= (command_check_fault && !cmd_valid) ||
				cmd_crc_fail;
			disallowed_command_fault <= (disallowed_command_fault &&
				!cmd_valid) || cmd_illegal;
		end
	end

	// assembled field; state, ready and ECC bits follow live inputs, lock bit the lock flag
	always_comb begin
		status_d = read_clear_q & `ST_READ_CLEAR_MASK;
		status_d[`ST_LOCKED_BIT] = card_locked_flag;
		status_d[`ST_CMD_CRC_BIT] = command_check_fault;
		status_d[`ST_ILLEGAL_BIT] = disallowed_command_fault;
		status_d[`ST_ECC_OFF_BIT] = ecc_disabled;
		status_d[`ST_STATE_LSB +: 4] = card_state;
		status_d[`ST_READY_BIT] = buffer_empty;
	end

	// live status and the snapshot carried by a response
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			card_status <= 32'h0000_0000;
			resp_status <= 32'h0000_0000;
		end else begin
			card_status <= status_d;
			if (cmd_valid) begin
				resp_status <= status_d;
			end
		end
	end

	// registered mirrors for the card's other logic
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			card_locked <= 1'b0;
			content_wipe <= 1'b0;
			engine_busy <= 1'b0;
		end else begin
			card_locked <= card_locked_flag;
			content_wipe <= erase_done; // whole-card wipe request
			engine_busy <= state_d != card_lock_pkg::ST_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	property p_unlock_match;
		state_q == card_lock_pkg::ST_FINISH && !mism_q && !session_q
			|=> !card_locked_flag ##1 !card_status[`ST_LOCKED_BIT];
	endproperty
	a_unlock_match: assert property (p_unlock_match)
		else $error("matching unlock left card locked");

	property p_unlock_mismatch;
		state_q == card_lock_pkg::ST_FINISH && mism_q
			|=> read_clear_q[`ST_LOCK_FAIL_BIT] && card_locked_flag;
	endproperty
	a_unlock_mismatch: assert property (p_unlock_mismatch)
		else $error("wrong password not flagged");

	property p_relock;
		session_q && stored_password_length != 8'h00 |=> card_locked_flag;
	endproperty
	a_relock: assert property (p_relock)
		else $error("stored password did not relock card");

	property p_unlock_unlocked;
		state_q == card_lock_pkg::ST_DECIDE && cnt_q == block_len &&
			mode_q == 8'h00 && !card_locked_flag
			|=> read_clear_q[`ST_LOCK_FAIL_BIT] &&
			state_q == card_lock_pkg::ST_IDLE;
	endproperty
	a_unlock_unlocked: assert property (p_unlock_unlocked)
		else $error("unlock of unlocked card not failed");

	property p_erase_reject;
		state_q == card_lock_pkg::ST_DECIDE && cnt_q == block_len &&
			mode_q[`MODE_ERASE_BIT] &&
			(mode_q != `MODE_ERASE_ONLY || !card_locked_flag)
			|=> read_clear_q[`ST_LOCK_FAIL_BIT] ##1 !content_wipe;
	endproperty
	a_erase_reject: assert property (p_erase_reject)
		else $error("bad forced erase not rejected");

	property p_erase_wipe;
		state_q == card_lock_pkg::ST_DECIDE && cnt_q == block_len &&
			mode_q == `MODE_ERASE_ONLY && card_locked_flag && !session_wr
			|=> (mem_we && mem_wdata == 32'h0000_0000)[*4]
			##1 content_wipe && !card_locked_flag &&
			stored_password_length == 8'h00;
	endproperty
	a_erase_wipe: assert property (p_erase_wipe)
		else $error("forced erase did not wipe and unlock");

	// both polarities: a stuck-high or stuck-low bit 25 fails here
	property p_locked_bit;
		card_status[`ST_LOCKED_BIT] == $past(card_locked_flag);
	endproperty
	a_locked_bit: assert property (p_locked_bit)
		else $error("locked bit does not follow lock state");

	property p_crc_clear;
		command_check_fault && cmd_valid && !cmd_crc_fail
			|=> !command_check_fault ##1 !card_status[`ST_CMD_CRC_BIT];
	endproperty
	a_crc_clear: assert property (p_crc_clear)
		else $error("check fault not cleared by valid command");

	// a set in the clearing cycle survives, so both cycles must be quiet
	property p_read_clear;
		cmd_valid && ev_flags == 32'h0000_0000 && !fail_set &&
			!locked_access && !len_fault_set ##1 ev_flags == 32'h0000_0000 &&
			!fail_set && !locked_access && !len_fault_set && !cmd_valid
			|=> (card_status & `ST_READ_CLEAR_MASK) == 32'h0000_0000;
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("read-clear bits survived a response");

	property p_state_field;
		cmd_valid |=> resp_status[12:9] == $past(card_state);
	endproperty
	a_state_field: assert property (p_state_field)
		else $error("response state field wrong");

	property p_ready_bit;
		buffer_empty |=> card_status[`ST_READY_BIT];
	endproperty
	a_ready_bit: assert property (p_ready_bit)
		else $error("ready bit does not follow buffer");

	c_unlock: cover property (state_q == card_lock_pkg::ST_FINISH &&
		!mism_q);
	c_mismatch: cover property (state_q == card_lock_pkg::ST_FINISH &&
		mism_q);
	c_erase: cover property (erase_done);
	c_status_read: cover property (status_rd && card_status != 32'h0);

endmodule

// *** rtl/pwd_store.sv ***
// small word memory holding the stored password, registered read data
`timescale 1ns/1ps
module pwd_store #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4,
	parameter int AW = 2
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);

	logic [WIDTH-1:0] mem [DEPTH];

	// no reset: contents survive a bus reset like the card's own store
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// read data registered, so consumers see it one cycle after raddr
	always_ff @(posedge clk) begin
		rdata <= mem[raddr];
	end

endmodule
